// ---- bench/alux_exec_properties.sv ----
// Port checker for the execution unit
`timescale 1ns/1ps
`default_nettype none
module alux_exec_properties
    import alux_pkg::*;
(
    // Clock and reset
    input wire logic                core_clk,
    input wire logic                nrst,
    // Watched ports
    input wire alux_pkg::alux_req_t req,
    input wire logic [7:0]          ioRdData,
    input wire alux_pkg::alux_rsp_t rsp,
    input wire logic [7:0]          flags
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic take;   // Request accepted
    logic isLog;  // Logic operation accepted
    logic bitOk;  // Address inside bit range
    logic selBit; // Addressed I/O bit
    assign take   = req.valid && !rsp.busy;
    assign isLog  = take && req.op inside {OP_AND, OP_OR, OP_XOR, OP_MASK_SET};
    assign bitOk  = req.ioAddr <= IO_BIT_LIMIT;
    assign selBit = ioRdData[req.ioBit];
    // Two steps of a pair operation
    sequence s_pairLow;
        rsp.busy && rsp.wrEn && !rsp.wrHigh;
    endsequence
    sequence s_pairHigh;
        rsp.wrEn && rsp.wrHigh && !rsp.busy;
    endsequence
    a_pair_two_steps: assert property (take && req.op inside {OP_PAIR_PLUS, OP_PAIR_MINUS} |=> s_pairLow ##1 s_pairHigh)
        else $error("pair operation steps wrong");
    a_sub_imm_result: assert property (take && req.op == OP_SUB_IMM |=> rsp.result == 8'($past(req.opA) - $past(req.opB))
        && flags[FLAG_C] == ($past(req.opB) > $past(req.opA)))
        else $error("immediate subtract wrong");
    a_logic_flags: assert property (isLog |=> !flags[FLAG_V] && flags[FLAG_Z] == (rsp.result == 8'h00)
        && flags[FLAG_N] == rsp.result[7])
        else $error("logic flags wrong");
    a_ones_carry: assert property (take && req.op == OP_ONES_INV |=> flags[FLAG_C] && rsp.result == ONES_CONST - $past(req.opA))
        else $error("ones invert wrong");
    a_io_one_bit: assert property (take && req.op inside {OP_IO_SET, OP_IO_CLEAR} && bitOk |=> rsp.ioWrEn
        && rsp.ioMask == 8'h01 << $past(req.ioBit) && rsp.ioValue == ($past(req.op) == OP_IO_SET))
        else $error("bit write wrong");
    a_io_range_limit: assert property (take && req.op inside {OP_IO_SET, OP_IO_CLEAR, OP_SKIP_HIGH, OP_SKIP_LOW} && !bitOk
        |=> !rsp.ioWrEn && !rsp.skip)
        else $error("bit access beyond range");
    a_skip_bit: assert property (take && req.op inside {OP_SKIP_HIGH, OP_SKIP_LOW} && bitOk
        |=> rsp.skip == ($past(selBit) == ($past(req.op) == OP_SKIP_HIGH)))
        else $error("skip decision wrong");
    a_flags_idle: assert property (!req.valid && !rsp.busy |=> $stable(flags))
        else $error("flags moved while idle");
endmodule : alux_exec_properties
bind alux_exec alux_exec_properties u_props (.core_clk(core_clk), .nrst(nrst), .req(req), .ioRdData(ioRdData),
    .rsp(rsp), .flags(flags));
`default_nettype wire

// ---- bench/alux_exec_tb_top.sv ----
// Directed bench for the execution unit
`timescale 1ns/1ps
`default_nettype none
module alux_exec_tb_top;
    import alux_pkg::*;
    logic       core_clk = 1'b0;
    logic       nrst = 1'b0;
    alux_req_t  req = '0;
    alux_rsp_t  rsp;
    logic [7:0] flags;
    logic [7:0] ioRdData;
    logic [7:0] fl; // Expected flags
    int         err_count = 0;
    int         samples_checked = 0;
    alux_exec u_dut (.core_clk(core_clk), .nrst(nrst), .req(req), .ioRdData(ioRdData), .rsp(rsp), .flags(flags));
    alux_io_space u_io (.core_clk(core_clk), .nrst(nrst), .rsp(rsp), .ioAddr(req.ioAddr), .ioRdData(ioRdData));
    // 125 MHz clock
    initial forever #4 core_clk = ~core_clk;
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("checks=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    // Expected byte result; updates expected flags
    function automatic logic [7:0] ref8(alux_op_t op, logic [7:0] a, logic [7:0] b);
        logic [8:0] s;
        logic [4:0] h;
        logic       c;
        logic       sb;
        logic       ar;
        c  = fl[FLAG_C] && op inside {OP_ADD_CARRY, OP_SUB_BORROW, OP_SUB_IMM_BRW};
        sb = op inside {OP_SUB, OP_SUB_IMM, OP_SUB_BORROW, OP_SUB_IMM_BRW, OP_TWOS_INV};
        ar = sb || op inside {OP_ADD, OP_ADD_CARRY};
        if (op == OP_TWOS_INV) begin
            b = a;
            a = ZERO_CONST;
        end
        s = sb ? {1'b0, a} - {1'b0, b} - c : {1'b0, a} + {1'b0, b} + c;
        h = sb ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - c : {1'b0, a[3:0]} + {1'b0, b[3:0]} + c;
        case (op)
            OP_AND: s = {1'b0, a & b};
            OP_OR, OP_MASK_SET: s = {1'b0, a | b};
            OP_XOR: s = {1'b0, a ^ b};
            OP_ONES_INV: s = {1'b1, ONES_CONST - a};
            default: ;
        endcase
        fl[FLAG_Z] = s[7:0] == 8'h00;
        fl[FLAG_N] = s[7];
        fl[FLAG_V] = ar && s[7] != a[7] && (sb ? a[7] != b[7] : a[7] == b[7]);
        if (ar || op == OP_ONES_INV) fl[FLAG_C] = s[8];
        if (ar) fl[FLAG_H] = h[4];
        return s[7:0];
    endfunction : ref8
    // Expected pair result; updates expected flags
    function automatic logic [15:0] ref16(logic sb, logic [15:0] p, logic [5:0] k);
        logic [15:0] r;
        r = sb ? p - k : p + k;
        fl[FLAG_Z] = r == 16'h0000;
        fl[FLAG_N] = r[15];
        fl[FLAG_V] = sb ? p[15] & ~r[15] : ~p[15] & r[15];
        fl[FLAG_C] = sb ? r[15] & ~p[15] : ~r[15] & p[15];
        fl[FLAG_S] = fl[FLAG_N] ^ fl[FLAG_V];
        return r;
    endfunction : ref16
    // Present one request; return in its answer cycle
    task automatic send(alux_req_t r, logic keep);
        @(negedge core_clk);
        req = r;
        @(negedge core_clk);
        req.valid = keep;
    endtask : send
    task automatic op8(alux_op_t op, logic [7:0] a, logic [7:0] b);
        logic [7:0] e;
        e = ref8(op, a, b);
        send('{valid:1'b1, op:op, opA:a, opB:b, default:'0}, 1'b0);
        chk({rsp.busy, rsp.wrHigh, rsp.wrEn, rsp.result}, {2'b00, 1'b1, e});
        chk(flags, fl);
    endtask : op8
    // Pair operation; the request stays up in the busy cycle and must be ignored
    task automatic op16(logic sb, logic [15:0] p, logic [5:0] k);
        logic [15:0] e;
        e = ref16(sb, p, k);
        send('{valid:1'b1, op:(sb ? OP_PAIR_MINUS : OP_PAIR_PLUS), opA:p[7:0], opB:p[15:8], wordImm:k, default:'0}, 1'b1);
        chk({rsp.busy, rsp.wrEn, rsp.result}, {2'b11, e[7:0]});
        @(negedge core_clk);
        req.valid = 1'b0;
        chk({flags, rsp.busy, rsp.wrHigh, rsp.wrEn, rsp.result}, {fl, 3'b011, e[15:8]});
    endtask : op16
    // Bit access; e is skip, write, value and mask
    task automatic opio(alux_op_t op, logic [5:0] ad, logic [2:0] bt, logic [10:0] e);
        send('{valid:1'b1, op:op, ioAddr:ad, ioBit:bt, default:'0}, 1'b0);
        chk({rsp.skip, rsp.ioWrEn, rsp.ioWrEn ? {rsp.ioAddr, rsp.ioValue, rsp.ioMask} : 15'h0000},
            {e[10:9], e[9] ? {ad, e[8:0]} : 15'h0000});
    endtask : opio
    // Hang guard
    initial begin
        #20us;
        err_count++;
        final_report();
    end
    // Main sequence
    initial begin
        repeat (3) @(negedge core_clk);
        chk(flags, FLAGS_RST);
        nrst = 1'b1;
        fl = FLAGS_RST;
        op8(OP_ADD, 8'h0f, 8'h01);
        op8(OP_ADD, 8'h80, 8'h80);
        op8(OP_ADD_CARRY, 8'h7f, 8'h00);
        op8(OP_SUB, 8'h00, 8'h01);
        op8(OP_SUB_BORROW, 8'h10, 8'h01);
        op8(OP_SUB_IMM, 8'h80, 8'h01);
        op8(OP_SUB_IMM_BRW, 8'h05, 8'h07);
        op8(OP_SUB_IMM_BRW, 8'h10, 8'h01);
        op8(OP_AND, 8'hf0, 8'h0f);
        op8(OP_OR, 8'h80, 8'h01);
        op8(OP_XOR, 8'haa, 8'h55);
        op8(OP_ONES_INV, 8'h00, 8'h00);
        op8(OP_TWOS_INV, 8'h80, 8'h00);
        op8(OP_TWOS_INV, 8'h00, 8'h00);
        op8(OP_MASK_SET, 8'h01, 8'h80);
        op16(1'b0, 16'hffff, 6'h01);
        op16(1'b0, 16'h7fc1, 6'h3f);
        op16(1'b1, 16'h0000, 6'h01);
        op16(1'b1, 16'h8000, 6'h01);
        opio(OP_IO_SET, 6'h1f, 3'd3, 11'h308);
        opio(OP_SKIP_HIGH, 6'h1f, 3'd3, 11'h400);
        opio(OP_SKIP_LOW, 6'h1f, 3'd3, 11'h000);
        opio(OP_IO_CLEAR, 6'h1f, 3'd3, 11'h208);
        opio(OP_SKIP_LOW, 6'h1f, 3'd3, 11'h400);
        opio(OP_IO_SET, 6'h20, 3'd3, 11'h000);
        opio(OP_SKIP_HIGH, 6'h20, 3'd3, 11'h000);
        opio(OP_IO_SET, 6'h0e, 3'd0, 11'h301);
        opio(OP_SKIP_HIGH, 6'h0e, 3'd7, 11'h400);
        opio(OP_IO_SET, 6'h0e, 3'd7, 11'h380);
        opio(OP_SKIP_HIGH, 6'h0e, 3'd7, 11'h000);
        final_report();
    end
endmodule : alux_exec_tb_top
`default_nettype wire

// ---- bench/alux_io_space.sv ----
// I/O register space model behind the bit-access port
`timescale 1ns/1ps
`default_nettype none
module alux_io_space
    import alux_pkg::*;
#(
    parameter logic [5:0] W1C_ADDR = 6'h0e, // Register with a write-one-to-clear flag
    parameter logic [7:0] W1C_BITS = 8'h80  // Flags cleared by writing one
)(
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                nrst,
    // Bit access from the unit
    input  wire alux_pkg::alux_rsp_t rsp,
    input  wire logic [5:0]          ioAddr,
    output logic [7:0]               ioRdData
);
    logic [7:0] mem [32]; // Low I/O range
    // Nothing answers above the range: show inverted bits
    assign ioRdData = (ioAddr <= IO_BIT_LIMIT) ? mem[ioAddr[4:0]] : ~mem[ioAddr[4:0]];
    // Merge single-bit writes; flag raised at reset
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            foreach (mem[i]) mem[i] <= (i == W1C_ADDR) ? W1C_BITS : 8'h00;
        end else if (rsp.ioWrEn && rsp.ioValue && rsp.ioAddr == W1C_ADDR && (rsp.ioMask & W1C_BITS) != 8'h00) begin
            mem[W1C_ADDR[4:0]] <= mem[W1C_ADDR[4:0]] & ~rsp.ioMask;
        end else if (rsp.ioWrEn) begin
            mem[rsp.ioAddr[4:0]] <= rsp.ioValue ? mem[rsp.ioAddr[4:0]] | rsp.ioMask
                                                : mem[rsp.ioAddr[4:0]] & ~rsp.ioMask;
        end
    end
endmodule : alux_io_space
`default_nettype wire

// ---- common/alux_pkg.sv ----
// Package of operation codes, flag positions and carriers for the arithmetic and logic execution unit
package alux_pkg;

    // Data and I/O widths
    localparam int          DATA_W        = 8;
    localparam int          IO_ADDR_W     = 6;
    localparam logic [5:0]  IO_BIT_LIMIT  = 6'h1f;   // Highest bit-addressable I/O address
    localparam logic [7:0]  ONES_CONST    = 8'hff;   // Minuend of the ones-complement
    localparam logic [7:0]  ZERO_CONST    = 8'h00;   // Minuend of the twos-complement

    // Flag positions in the status byte
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;

    // Reset value of the status flags
    localparam logic [7:0] FLAGS_RST = 8'h00;

    // Operation codes handed over by the decoder
    typedef enum logic [4:0] {
        OP_NONE        = 5'b00000,
        OP_ADD         = 5'b00001,
        OP_ADD_CARRY   = 5'b00010,
        OP_PAIR_PLUS   = 5'b00011,
        OP_SUB         = 5'b00100,
        OP_SUB_IMM     = 5'b00101,
        OP_SUB_BORROW  = 5'b00110,
        OP_SUB_IMM_BRW = 5'b00111,
        OP_PAIR_MINUS  = 5'b01000,
        OP_AND         = 5'b01001,
        OP_OR          = 5'b01010,
        OP_XOR         = 5'b01011,
        OP_ONES_INV    = 5'b01100,
        OP_TWOS_INV    = 5'b01101,
        OP_MASK_SET    = 5'b01110,
        OP_IO_SET      = 5'b01111,
        OP_IO_CLEAR    = 5'b10000,
        OP_SKIP_HIGH   = 5'b10001,
        OP_SKIP_LOW    = 5'b10010
    } alux_op_t;

    // Request from the decoder and register file
    typedef struct packed {
        logic                 valid;
        alux_op_t             op;
        logic [DATA_W-1:0]    opA;     // Destination / low byte of pair
        logic [DATA_W-1:0]    opB;     // Second register, immediate or high byte of pair
        logic [5:0]           wordImm; // Word immediate
        logic [IO_ADDR_W-1:0] ioAddr;
        logic [2:0]           ioBit;
    } alux_req_t;

    // Result towards the register file and I/O space
    typedef struct packed {
        logic              wrEn;      // Write result byte
        logic              wrHigh;    // Result targets the high byte of a pair
        logic [DATA_W-1:0] result;
        logic              ioWrEn;    // Single-bit I/O write
        logic [IO_ADDR_W-1:0] ioAddr;
        logic [DATA_W-1:0] ioMask;    // Only this bit changes
        logic              ioValue;
        logic              skip;      // Skip next instruction
        logic              busy;      // Second cycle of a word operation
    } alux_rsp_t;

    // Sequencer states
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_HIGH = 1'b1
    } alux_state_t;

    // Whole state of the unit
    typedef struct packed {
        alux_state_t       state;
        logic [7:0]        flags;
        logic [DATA_W-1:0] hiByte;   // Pending high byte of a pair
        logic              hiCarry;  // Carry or borrow from the low byte
        logic              hiSub;    // Pair subtract in progress
        logic              loZero;   // Low byte of pair was zero
        logic [DATA_W-1:0] lowRes;
        alux_rsp_t         rsp;
    } alux_regs_t;

endpackage : alux_pkg

// ---- hdl/alux_exec.sv ----
// Eight-bit arithmetic and logic execution unit with single-bit I/O access
`timescale 1ns/1ps
`default_nettype none

// Operation
// [RQ1] Add and add-with-carry, flags ZCNVH, one cycle
// [RQ2] Pair plus immediate, flags ZCNVS, two cycles
// [RQ3] Subtract and subtract-with-borrow, flags ZCNVH, one cycle
// [RQ4] Register minus immediate, flags ZCNVH, one cycle
// [RQ5] Register minus immediate and borrow, one cycle
// [RQ6] Pair minus immediate, flags ZCNVS, two cycles
// [RQ7] AND register or immediate, flags ZNV
// [RQ8] OR register or immediate, flags ZNV
// [RQ9] Exclusive-or of registers, flags ZNV
// [RQ10] Ones and twos invert with listed flags
// [RQ11] Mask set bits ORs immediate, flags ZNV
// [RQ12] Bit ops reach I/O addresses 0x00-0x1F only
// [RQ13] Bit set/clear alters only addressed bit
// [RQ14] Some I/O flags clear by writing one
// [RQ15] Skip tests one I/O bit, high or low
// [RQ16] Software writes reserved bits as zero
// [RQ17] Software never writes reserved I/O addresses
// [RQ18] Unlisted flags hold; carry taken before start
module alux_exec
    import alux_pkg::*;
(
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    // Request from the decoder
    input  wire alux_pkg::alux_req_t  req,
    // Current I/O register byte for bit tests
    input  wire logic [7:0]           ioRdData,
    // Result and status
    output var  alux_pkg::alux_rsp_t  rsp,
    output var  logic [7:0]           flags
);
    import alux_pkg::*;

    alux_regs_t r_q;   // Registered state
    alux_regs_t r_d;   // Next state

    // Zero test used by every flag-setting operation
    function automatic logic isZero(input logic [7:0] v);
        isZero = (v == 8'h00);
    endfunction : isZero

    // Eight-bit add or subtract with carry in, giving result, carry, half carry and overflow
    function automatic logic [10:0] addSub(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin, input logic sub);
        logic [8:0] full;
        logic [4:0] half;
        logic       ovf;
        if (sub) begin
            full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
            ovf  = (a[7] & ~b[7] & ~full[7]) | (~a[7] & b[7] & full[7]);
        end else begin
            full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            ovf  = (a[7] & b[7] & ~full[7]) | (~a[7] & ~b[7] & full[7]);
        end
        // {half carry, overflow, carry, result}
        addSub = {half[4], ovf, full[8], full[7:0]};
    endfunction : addSub

    // Next-state logic
    always_comb begin
        logic [10:0] ar;
        logic [7:0]  res;
        logic [7:0]  f;
        logic        doAr;
        logic        arSub;
        logic        useC;
        logic [7:0]  bOp;
        logic [7:0]  aOp;
        logic        setH;
        logic        bitReach;
        ar       = '0;
        res      = 8'h00;
        f        = r_q.flags;  // Flags not named below keep their value [RQ18]
        doAr     = 1'b0;
        arSub    = 1'b0;
        useC     = 1'b0;
        bOp      = req.opB;
        aOp      = req.opA;
        setH     = 1'b1;
        bitReach = (req.ioAddr <= IO_BIT_LIMIT);   // [RQ12]
        r_d      = r_q;
        r_d.rsp  = '0;

        unique case (r_q.state)
            ST_IDLE: begin
                if (req.valid) begin
                    unique case (req.op)
                        OP_ADD: begin
                            doAr = 1'b1;  // [RQ1]
                        end
                        OP_ADD_CARRY: begin
                            doAr = 1'b1;  // [RQ1]
                            useC = 1'b1;
                        end
                        OP_SUB, OP_SUB_IMM: begin
                            doAr  = 1'b1;  // [RQ3] [RQ4]
                            arSub = 1'b1;
                        end
                        OP_SUB_BORROW, OP_SUB_IMM_BRW: begin
                            doAr  = 1'b1;  // [RQ3] [RQ5]
                            arSub = 1'b1;
                            useC  = 1'b1;
                        end
                        OP_TWOS_INV: begin
                            doAr  = 1'b1;  // [RQ10]
                            arSub = 1'b1;
                            aOp   = ZERO_CONST;
                            bOp   = req.opA;
                        end
                        OP_PAIR_PLUS, OP_PAIR_MINUS: begin
                            // Low byte now, high byte next cycle [RQ2] [RQ6]
                            arSub = (req.op == OP_PAIR_MINUS);
                            ar    = addSub(req.opA, {2'b00, req.wordImm}, 1'b0, arSub);
                            r_d.lowRes     = ar[7:0];
                            r_d.hiByte     = req.opB;
                            r_d.hiCarry    = ar[8];
                            r_d.hiSub      = arSub;
                            r_d.loZero     = isZero(ar[7:0]);
                            r_d.rsp.wrEn   = 1'b1;
                            r_d.rsp.result = ar[7:0];
                            r_d.rsp.busy   = 1'b1;
                            r_d.state      = ST_HIGH;
                        end
                        OP_AND, OP_OR, OP_XOR, OP_MASK_SET: begin
                            // Logic group updates only Z, N and V [RQ7] [RQ8] [RQ9] [RQ11]
                            if (req.op == OP_AND) begin
                                res = req.opA & req.opB;
                            end else if (req.op == OP_XOR) begin
                                res = req.opA ^ req.opB;
                            end else begin
                                res = req.opA | req.opB;
                            end
                            f[FLAG_Z] = isZero(res);
                            f[FLAG_N] = res[7];
                            f[FLAG_V] = 1'b0;
                            r_d.rsp.wrEn   = 1'b1;
                            r_d.rsp.result = res;
                        end
                        OP_ONES_INV: begin
                            res = ONES_CONST - req.opA;  // [RQ10]
                            f[FLAG_Z] = isZero(res);
                            f[FLAG_C] = 1'b1;
                            f[FLAG_N] = res[7];
                            f[FLAG_V] = 1'b0;
                            r_d.rsp.wrEn   = 1'b1;
                            r_d.rsp.result = res;
                        end
                        OP_IO_SET, OP_IO_CLEAR: begin
                            // Only the addressed bit is written, so write-one-to-clear
                            // neighbours are untouched [RQ13] [RQ14]
                            if (bitReach) begin
                                r_d.rsp.ioWrEn  = 1'b1;
                                r_d.rsp.ioAddr  = req.ioAddr;
                                r_d.rsp.ioMask  = 8'h01 << req.ioBit;
                                r_d.rsp.ioValue = (req.op == OP_IO_SET);
                            end
                        end
                        OP_SKIP_HIGH, OP_SKIP_LOW: begin
                            // Skip on the sampled bit [RQ15]
                            if (bitReach) begin
                                r_d.rsp.skip = (req.op == OP_SKIP_HIGH) ? ioRdData[req.ioBit]
                                                                         : ~ioRdData[req.ioBit];
                            end
                        end
                        default: begin
                            // No operation
                        end
                    endcase

                    // Shared byte adder; carry taken from flags before this cycle [RQ18]
                    if (doAr) begin
                        ar = addSub(aOp, bOp, useC & r_q.flags[FLAG_C], arSub);
                        f[FLAG_Z] = isZero(ar[7:0]);
                        f[FLAG_C] = ar[8];
                        f[FLAG_N] = ar[7];
                        f[FLAG_V] = ar[9];
                        if (setH) begin
                            f[FLAG_H] = ar[10];
                        end
                        r_d.rsp.wrEn   = 1'b1;
                        r_d.rsp.result = ar[7:0];
                    end
                end
            end
            ST_HIGH: begin
                // High byte of a pair, then word flags [RQ2] [RQ6]
                ar = addSub(r_q.hiByte, 8'h00, r_q.hiCarry, r_q.hiSub);
                f[FLAG_Z] = r_q.loZero & isZero(ar[7:0]);
                f[FLAG_N] = ar[7];
                f[FLAG_V] = r_q.hiSub ? (r_q.hiByte[7] & ~ar[7]) : (~r_q.hiByte[7] & ar[7]);
                f[FLAG_C] = r_q.hiSub ? (~r_q.hiByte[7] & ar[7]) : (r_q.hiByte[7] & ~ar[7]);
                f[FLAG_S] = ar[7] ^ f[FLAG_V];
                r_d.rsp.wrEn   = 1'b1;
                r_d.rsp.wrHigh = 1'b1;
                r_d.rsp.result = ar[7:0];
                r_d.state      = ST_IDLE;
            end
            default: begin
                r_d.state = ST_IDLE;
            end
        endcase
        r_d.flags = f;
    end

    // State register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            r_q       <= '0;
            r_q.flags <= FLAGS_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs straight from flip-flops
    assign rsp   = r_q.rsp;
    assign flags = r_q.flags;

endmodule : alux_exec
`default_nettype wire
